//--- sckp_top.sv
`timescale 1ns/1ps
// Purpose: System clock prescaler, RC trim and clock switch registers
// Assumes: Software is the only party at the register port
// Notes: Source oscillators outside; ready comes from a counted source tick
//
// Contract
// - one divided enable for all clocks
// - divider reloads only at period end
// - new ratio after old plus new period
// - change enable set only by lone write
// - enable clears after four cycles or use
// - rewrite neither restarts nor clears enable
// - divider bits 6:4 read zero
// - reset code from divide-by-eight fuse
// - any division code accepted
// - codes 0 to 8 give 1 to 256
// - trim loads factory value on first edge after reset
// - trim code drives oscillator monotonically
// - command codes 1 to 5 decoded
// - selection holds source and start-up code
// - command only within open enable window
// - ready clears on enable or request, sets when counted
module sckp_top
   import sckp_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [7:0] reg_rdata,
   // Straps and factory data
   input wire logic divide_by_eight_fuse,
   input wire logic [7:0] factory_trim,
   input wire logic [7:0] fuse_clock_select,
   // Source oscillator side
   input wire logic source_tick,
   output logic [7:0] trim_code,
   output logic rc_frequency_select,
   output logic [3:0] source_code,
   output logic [1:0] startup_code,
   output logic source_enable_pulse,
   output logic source_disable_pulse,
   output logic switch_pulse,
   // Divided clock enable
   output logic sys_clk_enable
);
   // ****************************************************
   // State
   // ****************************************************
   typedef struct packed {
      logic loaded;
      logic [7:0] trim;
      logic [3:0] div_sel;
      logic [7:0] sel;
      logic [3:0] system_src;
      logic rc_sel;
      logic [15:0] rdy_count;
      sckp_rdy_state_t rdy_state;
      logic rdy;
      logic tick_q1;
      logic tick_q2;
      logic tick_q3;
      logic en_p;
      logic dis_p;
      logic sw_p;
      logic [7:0] rdata;
   } sckp_state_t;
   sckp_state_t st, next_st;
   sckp_ctl_if ctl ();
   logic div_open;
   logic cmd_open;
   logic div_arm;
   logic div_use;
   logic cmd_arm;
   logic cmd_use;
   logic wr_div;
   logic wr_cmd;
   function automatic logic lone_ce(input logic [7:0] d);
      lone_ce = (d == 8'h80);
   endfunction
   assign wr_div = reg_write && reg_addr == SCKP_ADDR_DIV;
   assign wr_cmd = reg_write && reg_addr == SCKP_ADDR_CMD;
   assign div_arm = wr_div && lone_ce(reg_wdata);
   assign div_use = wr_div && div_open && !reg_wdata[SCKP_CE_BIT];
   assign cmd_arm = wr_cmd && lone_ce(reg_wdata);
   assign cmd_use = wr_cmd && cmd_open && !reg_wdata[SCKP_CE_BIT];
   // ****************************************************
   // Change-enable windows
   // ****************************************************
   sckp_timed_gate u_div_gate (
      .clk(clk),
      .resetn(resetn),
      .arm(div_arm),
      .consume(div_use),
      .open(div_open)
   );
   sckp_timed_gate u_cmd_gate (
      .clk(clk),
      .resetn(resetn),
      .arm(cmd_arm),
      .consume(cmd_use),
      .open(cmd_open)
   );
   sckp_divider u_divider (
      .clk(clk),
      .resetn(resetn),
      .ctl(ctl.div)
   );
   assign ctl.division_select = st.div_sel;
   // ****************************************************
   // Next state
   // ****************************************************
   always_comb begin
      next_st = st;
      next_st.en_p = 1'b0;
      next_st.dis_p = 1'b0;
      next_st.sw_p = 1'b0;
      next_st.tick_q1 = source_tick;
      next_st.tick_q2 = st.tick_q1;
      next_st.tick_q3 = st.tick_q2;
      // Straps caught on the first edge after release, not in reset
      if (!st.loaded) begin
         next_st.loaded = 1'b1;
         next_st.trim = factory_trim;
         next_st.div_sel = divide_by_eight_fuse ? SCKP_DIV_RST_FUSE_ON
                                                : SCKP_DIV_RST_FUSE_OFF;
         next_st.sel = fuse_clock_select & 8'h3F;
         next_st.system_src = fuse_clock_select[3:0];
      end
      // Ready counter on synchronised source ticks
      case (st.rdy_state)
         SCKP_RDY_IDLE: begin
         end
         SCKP_RDY_COUNTING: begin
            if (st.tick_q2 && !st.tick_q3) begin
               next_st.rdy_count = st.rdy_count - 16'h0001;
               if (st.rdy_count == 16'h0001) begin
                  next_st.rdy = 1'b1;
                  next_st.rdy_state = SCKP_RDY_DONE;
               end
            end
         end
         SCKP_RDY_DONE: begin
         end
         default: begin
            next_st.rdy_state = SCKP_RDY_IDLE;
         end
      endcase
      if (reg_write) begin
         case (reg_addr)
            SCKP_ADDR_TRIM: begin
               next_st.trim = reg_wdata;
            end
            SCKP_ADDR_DIV: begin
               if (div_use) begin
                  next_st.div_sel = reg_wdata[3:0];
               end
            end
            SCKP_ADDR_SEL: begin
               next_st.sel = reg_wdata & (SCKP_SEL_SRC_MASK | SCKP_SEL_SUT_MASK);
            end
            SCKP_ADDR_MCU: begin
               next_st.rc_sel = reg_wdata[SCKP_RCSEL_BIT];
            end
            default: begin
            end
         endcase
      end
      if (cmd_use) begin
         case (reg_wdata[3:0])
            SCKP_CMD_DISABLE: begin
               // Refused for the source now driving the system
               next_st.dis_p = (st.sel[3:0] != st.system_src);
            end
            SCKP_CMD_ENABLE, SCKP_CMD_REQUEST: begin
               next_st.en_p = (reg_wdata[3:0] == SCKP_CMD_ENABLE);
               next_st.rdy = 1'b0;
               next_st.rdy_count = SCKP_RDY_COUNT;
               next_st.rdy_state = SCKP_RDY_COUNTING;
            end
            SCKP_CMD_SWITCH: begin
               next_st.sw_p = 1'b1;
               next_st.system_src = st.sel[3:0];
            end
            SCKP_CMD_RECOVER: begin
               next_st.sel[3:0] = st.system_src;
            end
            default: begin
            end
         endcase
      end
      next_st.rdata = 8'h00;
      if (reg_read) begin
         case (reg_addr)
            SCKP_ADDR_TRIM: next_st.rdata = st.trim;
            SCKP_ADDR_DIV: next_st.rdata = {div_open, 3'b000, st.div_sel};
            SCKP_ADDR_CMD: next_st.rdata = {cmd_open, 2'b00, st.rdy, 4'h0};
            SCKP_ADDR_SEL: next_st.rdata = st.sel;
            SCKP_ADDR_MCU: next_st.rdata = {5'h00, st.rc_sel, 2'b00};
            default: next_st.rdata = 8'h00;
         endcase
      end
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
         st.rdy_state <= SCKP_RDY_IDLE;
         st.trim <= SCKP_TRIM_RST;
         st.sel <= SCKP_SEL_RST;
      end else begin
         st <= next_st;
      end
   end
   // ****************************************************
   // Outputs
   // ****************************************************
   assign reg_rdata = st.rdata;
   assign trim_code = st.trim;
   assign rc_frequency_select = st.rc_sel;
   assign source_code = st.sel[3:0];
   assign startup_code = st.sel[5:4];
   assign source_enable_pulse = st.en_p;
   assign source_disable_pulse = st.dis_p;
   assign switch_pulse = st.sw_p;
   assign sys_clk_enable = ctl.clk_enable;
endmodule // sckp_top

//--- sckp_pkg.sv
// Purpose: Shared constants and types for the system clock prescaler and switch
// Assumes: One 100 MHz master clock, plain register port
// Notes: Register offsets are byte addresses on the plain port
package sckp_pkg;
   // ****************************************************
   // Register map
   // ****************************************************
   localparam logic [3:0] SCKP_ADDR_TRIM = 4'h0;
   localparam logic [3:0] SCKP_ADDR_DIV = 4'h1;
   localparam logic [3:0] SCKP_ADDR_CMD = 4'h2;
   localparam logic [3:0] SCKP_ADDR_SEL = 4'h3;
   localparam logic [3:0] SCKP_ADDR_MCU = 4'h4;
   // ****************************************************
   // Fields and values
   // ****************************************************
   localparam int SCKP_CE_BIT = 7;
   localparam int SCKP_RDY_BIT = 4;
   localparam int SCKP_RCSEL_BIT = 2;
   localparam logic [3:0] SCKP_DIV_RST_FUSE_OFF = 4'h0;
   localparam logic [3:0] SCKP_DIV_RST_FUSE_ON = 4'h3;
   localparam logic [3:0] SCKP_DIV_MAX = 4'h8;
   localparam logic [7:0] SCKP_SEL_SRC_MASK = 8'h0F;
   localparam logic [7:0] SCKP_SEL_SUT_MASK = 8'h30;
   localparam logic [7:0] SCKP_SEL_RST = 8'h00;
   localparam logic [7:0] SCKP_TRIM_RST = 8'h00;
   localparam logic [2:0] SCKP_CE_WINDOW = 3'h4;
   localparam logic [15:0] SCKP_RDY_COUNT = 16'h0040;
   // ****************************************************
   // Clock commands
   // ****************************************************
   localparam logic [3:0] SCKP_CMD_DISABLE = 4'h1;
   localparam logic [3:0] SCKP_CMD_ENABLE = 4'h2;
   localparam logic [3:0] SCKP_CMD_REQUEST = 4'h3;
   localparam logic [3:0] SCKP_CMD_SWITCH = 4'h4;
   localparam logic [3:0] SCKP_CMD_RECOVER = 4'h5;
   typedef enum logic [2:0] {
      SCKP_RDY_IDLE = 3'b001,
      SCKP_RDY_COUNTING = 3'b010,
      SCKP_RDY_DONE = 3'b100
   } sckp_rdy_state_t;
endpackage : sckp_pkg

//--- sckp_ctl_if.sv
`timescale 1ns/1ps
// Purpose: Division setting passed from register logic to the prescaler
// Assumes: Same clock on both sides
// Notes: None
interface sckp_ctl_if;
   logic [3:0] division_select;
   logic clk_enable;
   modport regs (output division_select, input clk_enable);
   modport div (input division_select, output clk_enable);
endinterface : sckp_ctl_if

//--- sckp_timed_gate.sv
`timescale 1ns/1ps
// Purpose: Change-enable bit with a fixed four-cycle timeout
// Assumes: arm and consume come from same-clock logic
// Notes: Re-arming while open neither extends nor clears
module sckp_timed_gate
   import sckp_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Control
   input wire logic arm,
   input wire logic consume,
   // Status
   output logic open
);
   typedef struct packed {
      logic open;
      logic [2:0] count;
   } sckp_gate_t;
   sckp_gate_t st, next_st;
   always_comb begin
      next_st = st;
      if (st.open) begin
         next_st.count = st.count - 3'h1;
         if (consume || st.count == 3'h1) begin
            next_st.open = 1'b0;
         end
      end else if (arm) begin
         next_st.open = 1'b1;
         next_st.count = SCKP_CE_WINDOW;
      end
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign open = st.open;
endmodule // sckp_timed_gate

//--- sckp_divider.sv
`timescale 1ns/1ps
// Purpose: Glitch-free power-of-two clock enable divider
// Assumes: Master clock undivided, division code from registers
// Notes: New code is taken only at the end of a divided period
module sckp_divider
   import sckp_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Setting and enable
   sckp_ctl_if.div ctl
);
   typedef struct packed {
      logic [7:0] count;
      logic [3:0] active;
      logic en;
   } sckp_div_t;
   sckp_div_t st, next_st;
   function automatic logic [7:0] sckp_limit(input logic [3:0] code);
      logic [3:0] c;
      c = (code > SCKP_DIV_MAX) ? SCKP_DIV_MAX : code;
      if (c == SCKP_DIV_MAX) begin
         sckp_limit = 8'hFF;
      end else begin
         sckp_limit = 8'((9'h001 << c) - 9'h001);
      end
   endfunction
   always_comb begin
      next_st = st;
      next_st.en = 1'b0;
      // Reload only at period end: no short pulse, no faster burst
      if (st.count >= sckp_limit(st.active)) begin
         next_st.count = 8'h00;
         next_st.en = 1'b1;
         next_st.active = ctl.division_select;
      end else begin
         next_st.count = st.count + 8'h01;
      end
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   // Single enable serves CPU, I/O, ADC and flash alike
   assign ctl.clk_enable = st.en;
endmodule // sckp_divider

//--- sckp_props.sv
// Purpose: Port-level checks of the clock prescaler and switch
// Assumes: Sees only top-level ports
// Notes: Bound to every sckp_top instance
`timescale 1ns/1ps
module sckp_props
   import sckp_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   // Outputs
   input wire logic [7:0] trim_code,
   input wire logic [3:0] source_code,
   input wire logic [1:0] startup_code,
   input wire logic source_enable_pulse,
   input wire logic source_disable_pulse,
   input wire logic switch_pulse,
   input wire logic sys_clk_enable
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_wr(logic [3:0] a, logic [7:0] d);
      reg_write && reg_addr == a && reg_wdata == d;
   endsequence
   a_rdata_idle: assert property (!reg_read |=> reg_rdata == 8'h00)
      else $error("read data not zero outside read");
   a_div_reserved: assert property (reg_read && reg_addr == SCKP_ADDR_DIV |=>
      reg_rdata[6:4] == 3'h0) else $error("divider reserved bits not zero");
   a_trim_follows: assert property (reg_write && reg_addr == SCKP_ADDR_TRIM |=>
      trim_code == $past(reg_wdata)) else $error("trim output not updated");
   a_sel_follows: assert property (reg_write && reg_addr == SCKP_ADDR_SEL |=>
      source_code == $past(reg_wdata[3:0]) && startup_code == $past(reg_wdata[5:4]))
      else $error("selection outputs not updated");
   a_enable_cause: assert property (source_enable_pulse |->
      $past(reg_write) && $past(reg_addr) == SCKP_ADDR_CMD && $past(reg_wdata) == 8'h02)
      else $error("enable pulse without command");
   a_disable_cause: assert property (source_disable_pulse |->
      $past(reg_write) && $past(reg_addr) == SCKP_ADDR_CMD && $past(reg_wdata) == 8'h01)
      else $error("disable pulse without command");
   a_switch_window: assert property (s_wr(SCKP_ADDR_CMD, 8'h80) ##1
      s_wr(SCKP_ADDR_CMD, 8'h04) |=> switch_pulse) else $error("armed switch lost");
   a_switch_late: assert property (s_wr(SCKP_ADDR_CMD, 8'h80) ##1 (!reg_write)[*5] ##1
      s_wr(SCKP_ADDR_CMD, 8'h04) |=> !switch_pulse) else $error("late switch accepted");
   a_enable_gap: assert property (sys_clk_enable |=> ##[0:255] sys_clk_enable)
      else $error("divided enable gap above 256");
endmodule // sckp_props

bind sckp_top sckp_props sckp_props_inst (.clk(clk), .resetn(resetn),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
   .reg_read(reg_read), .reg_rdata(reg_rdata), .trim_code(trim_code),
   .source_code(source_code), .startup_code(startup_code),
   .source_enable_pulse(source_enable_pulse), .source_disable_pulse(source_disable_pulse),
   .switch_pulse(switch_pulse), .sys_clk_enable(sys_clk_enable));

//--- testbench.sv
// Purpose: Self-checking bench for the clock prescaler and switch
// Assumes: Bench is the only register master
// Notes: Source ticks come from a bench toggle
`timescale 1ns/1ps
module testbench;
   import sckp_pkg::*;
   logic clk = 0;
   logic resetn = 0;
   logic reg_write = 0;
   logic reg_read = 0;
   logic divide_by_eight_fuse = 1;
   logic source_tick = 0;
   logic tick_run = 0;
   logic [3:0] reg_addr = 0;
   logic [7:0] reg_wdata = 0;
   logic [7:0] factory_trim = 0;
   logic [7:0] fuse_clock_select = 0;
   logic [7:0] reg_rdata, trim_code, d, t;
   logic [3:0] source_code, s;
   logic [1:0] startup_code;
   logic [2:0] p;
   logic rc_frequency_select, source_enable_pulse, source_disable_pulse;
   logic switch_pulse, sys_clk_enable;
   int num_errors = 0;
   int compares = 0;
   int n;
   sckp_top sckp_top_inst (.clk, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
      .reg_rdata, .divide_by_eight_fuse, .factory_trim, .fuse_clock_select, .source_tick,
      .trim_code, .rc_frequency_select, .source_code, .startup_code, .source_enable_pulse,
      .source_disable_pulse, .switch_pulse, .sys_clk_enable);
   initial begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (tick_run) source_tick <= ~source_tick;
   end
   function automatic int ratio(logic [3:0] c);
      return (c >= 4'h8) ? 256 : (1 << c);
   endfunction
   task automatic end_sim();
      $display("Compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wr(logic [3:0] a, logic [7:0] v);
      reg_read <= 0;
      reg_write <= 1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge clk);
   endtask
   task automatic idle(int k);
      reg_write <= 0;
      repeat (k) @(posedge clk);
   endtask
   task automatic rd(logic [3:0] a, output logic [7:0] v);
      reg_write <= 0;
      reg_read <= 1;
      reg_addr <= a;
      @(posedge clk);
      reg_read <= 0;
      #1 v = reg_rdata;
      @(posedge clk);
   endtask
   // Pre below zero skips arming, above zero idles pre cycles, late from four
   task automatic cmd(logic [7:0] c, int pre, output logic [2:0] q);
      if (pre >= 0) wr(SCKP_ADDR_CMD, 8'h80);
      if (pre > 0) idle(pre);
      wr(SCKP_ADDR_CMD, c);
      reg_write <= 0;
      #1 q = {source_enable_pulse, source_disable_pulse, switch_pulse};
      @(posedge clk);
   endtask
   task automatic gap(output int k);
      k = 0;
      do begin
         @(posedge clk);
         #1 k++;
      end while (sys_clk_enable !== 1'b1 && k < 300);
      if (k >= 300) begin
         num_errors++;
         end_sim();
      end
   endtask
   task automatic set_div(logic [3:0] c);
      wr(SCKP_ADDR_DIV, 8'h80);
      wr(SCKP_ADDR_DIV, {4'h0, c});
   endtask
   initial begin
      void'($urandom(32'hacf7_e4ed));
      factory_trim <= 8'($urandom);
      fuse_clock_select <= 8'($urandom);
      repeat (10) @(posedge clk);
      resetn <= 1;
      @(posedge clk);
      rd(SCKP_ADDR_TRIM, d);
      chk("trim_reset", d, factory_trim);
      rd(SCKP_ADDR_DIV, d);
      chk("div_reset", d, 8'h03);
      rd(SCKP_ADDR_SEL, d);
      chk("sel_reset", d, {2'b00, fuse_clock_select[5:0]});
      wr(4'hF, 8'hFF);
      rd(4'hF, d);
      chk("unmapped", d, 8'h00);
      // ****************************************************
      // Prescaler
      // ****************************************************
      wr(SCKP_ADDR_DIV, 8'h80);
      rd(SCKP_ADDR_DIV, d);
      chk("ce_set", d, 8'h83);
      for (int i = 0; i < 10; i++) begin
         set_div(i[3:0]);
         rd(SCKP_ADDR_DIV, d);
         chk("div_code", d, {4'h0, i[3:0]});
         gap(n);
         gap(n);
         gap(n);
         chk("ratio", 16'(n), 16'(ratio(i[3:0])));
      end
      set_div(4'h2);
      wr(SCKP_ADDR_DIV, 8'h81);
      wr(SCKP_ADDR_DIV, 8'h05);
      idle(1);
      rd(SCKP_ADDR_DIV, d);
      chk("impure_arm", d, 8'h02);
      wr(SCKP_ADDR_DIV, 8'h80);
      idle(5);
      wr(SCKP_ADDR_DIV, 8'h06);
      rd(SCKP_ADDR_DIV, d);
      chk("ce_timeout", d, 8'h02);
      wr(SCKP_ADDR_DIV, 8'h80);
      idle(1);
      wr(SCKP_ADDR_DIV, 8'h80);
      idle(2);
      wr(SCKP_ADDR_DIV, 8'h07);
      rd(SCKP_ADDR_DIV, d);
      chk("no_restart", d, 8'h02);
      wr(SCKP_ADDR_DIV, 8'h80);
      wr(SCKP_ADDR_DIV, 8'h80);
      wr(SCKP_ADDR_DIV, 8'h01);
      rd(SCKP_ADDR_DIV, d);
      chk("no_clear", d, 8'h01);
      // ****************************************************
      // Trim, RC select and clock switch
      // ****************************************************
      t = 8'($urandom);
      wr(SCKP_ADDR_TRIM, t);
      rd(SCKP_ADDR_TRIM, d);
      chk("trim_rw", {d, trim_code}, {t, t});
      wr(SCKP_ADDR_MCU, 8'h04);
      idle(1);
      chk("rc_select", rc_frequency_select, 1'b1);
      s = 4'($urandom_range(15, 1));
      // One source enabled, start-up code 2
      wr(SCKP_ADDR_SEL, {4'h2, s});
      cmd(8'h02, 0, p);
      chk("enable", {p, startup_code, source_code}, {3'b100, 2'b10, s});
      rd(SCKP_ADDR_CMD, d);
      chk("ready_clear", d[4], 1'b0);
      tick_run <= 1;
      n = 0;
      do begin
         rd(SCKP_ADDR_CMD, d);
         n++;
      end while (d[4] !== 1'b1 && n < 200);
      chk("ready_set", d[4], 1'b1);
      if (n >= 200) end_sim();
      tick_run <= 0;
      cmd(8'h04, -1, p);
      chk("unarmed", p, 3'b000);
      cmd(8'h04, 5, p);
      chk("late", p, 3'b000);
      cmd(8'h04, 0, p);
      chk("switch", p, 3'b001);
      wr(SCKP_ADDR_SEL, 8'h00);
      cmd(8'h05, 0, p);
      rd(SCKP_ADDR_SEL, d);
      chk("recover", d, {4'h0, s});
      wr(SCKP_ADDR_SEL, {4'h0, s});
      cmd(8'h01, 0, p);
      chk("dis_current", p, 3'b000);
      wr(SCKP_ADDR_SEL, {4'h0, s ^ 4'h1});
      cmd(8'h01, 0, p);
      chk("dis_other", p, 3'b010);
      cmd(8'h03, 0, p);
      rd(SCKP_ADDR_CMD, d);
      chk("request_clear", d[4], 1'b0);
      resetn <= 0;
      divide_by_eight_fuse <= 0;
      repeat (3) @(posedge clk);
      resetn <= 1;
      @(posedge clk);
      rd(SCKP_ADDR_DIV, d);
      chk("div_reset_off", d, 8'h00);
      end_sim();
   end
endmodule // testbench
